// ### src/sdp_port.sv
`timescale 1ns/1ns
// =========================================================
// One port: input registers, burst counter, write, read
// =========================================================
module sdp_port
    import sdp_pkg::*;
#(
    parameter int AW = ADDR_W_128K
)(
    input  wire logic              mclk_in,
    input  wire logic              reset_n_in,
    input  wire sdp_ctrl_type      ctrl_in,
    input  wire logic [AW-1:0]     addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic [DATA_W-1:0] mem_rdata_in,
    output logic [AW-1:0]          mem_addr_out,
    output logic                   mem_we_out,
    output logic [BYTE_LANES-1:0]  mem_be_out,
    output logic [DATA_W-1:0]      mem_wdata_out,
    output logic [DATA_W-1:0]      rdata_out,
    output logic                   rvalid_out,
    output logic                   wrap_flag_out
);
    // =========================================================
    // Input registers
    // =========================================================
    sdp_ctrl_type      ctrl_q;
    logic [AW-1:0]     addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [AW-1:0]     counter;
    logic [AW-1:0]     mask;
    logic              enabled;
    logic              active;
    logic              rd_pend;

    always_ff @(posedge mclk_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            ctrl_q  <= '{default: '1, chip_sel_high_active: 1'b0};
            addr_q  <= '0;
            wdata_q <= '0;
        end
        else
        begin
            ctrl_q  <= ctrl_in;
            addr_q  <= addr_in;
            wdata_q <= wdata_in;
        end

    wire sel = !ctrl_q.chip_sel_low_active && ctrl_q.chip_sel_high_active;
    wire load = sel && !ctrl_q.addr_strobe_n;
    wire incr = sel && ctrl_q.addr_strobe_n && !ctrl_q.cnt_en_n;
    wire [AW-1:0] masked  = counter & mask;
    wire          at_top  = (masked == mask);
    wire [AW-1:0] next_counter = at_top ? (counter & ~mask)
                                        : ((counter & ~mask) | ((masked + 1'b1) & mask));
    // Counting cycle uses the stepped address, so a burst moves on right after a load
    wire [AW-1:0] eff_addr = load ? addr_q : (incr ? next_counter : counter);

    // =========================================================
    // Counter, mask and wrap flag
    // =========================================================
    // load then advance
    always_ff @(posedge mclk_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            counter       <= '0;
            mask          <= '1;
            wrap_flag_out <= WRAP_RESET;
        end
        else
        begin
            if (sel && !ctrl_q.mask_load_n)
                mask <= addr_q;
            else if (load)
                counter <= addr_q;
            else if (incr)
                counter <= next_counter;
            if (incr && at_top)
                wrap_flag_out <= 1'b1;
            else if (load)
                wrap_flag_out <= 1'b0;
        end

    assign mem_addr_out  = eff_addr;
    assign mem_we_out    = sel && !ctrl_q.write_n && ctrl_q.mask_load_n;
    assign mem_be_out    = ~ctrl_q.byte_en_n;
    assign mem_wdata_out = wdata_q;

    // =========================================================
    // Output register
    // =========================================================
    // Outputs stay off until one selected cycle follows power-down
    always_ff @(posedge mclk_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            enabled    <= 1'b0;
            active     <= 1'b0;
            rd_pend    <= 1'b0;
            rdata_out  <= RDATA_RESET;
            rvalid_out <= 1'b0;
        end
        else
        begin
            enabled    <= sel;
            active     <= sel && enabled;
            rd_pend    <= sel && ctrl_q.write_n && ctrl_q.mask_load_n;
            rvalid_out <= rd_pend && active;
            if (rd_pend && active)
                rdata_out <= mem_rdata_in;
        end
endmodule : sdp_port

// ### shared/sdp_pkg.sv
package sdp_pkg;

    // =========================================================
    // Geometry
    // =========================================================
    localparam int ADDR_W_128K = 17;
    localparam int ADDR_W_256K = 18;
    localparam int ADDR_W_512K = 19;
    localparam int DATA_W      = 18;
    localparam int BYTE_W      = 9;
    localparam int BYTE_LANES  = 2;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [DATA_W-1:0] RDATA_RESET = 18'h00000;
    localparam logic              WRAP_RESET  = 1'b0;

    // Host request of one port
    typedef struct packed {
        logic                  chip_sel_low_active;
        logic                  chip_sel_high_active;
        logic                  addr_strobe_n;
        logic                  cnt_en_n;
        logic                  mask_load_n;
        logic                  write_n;
        logic [BYTE_LANES-1:0] byte_en_n;
    } sdp_ctrl_type;

endpackage : sdp_pkg

// ### src/sdp_ram.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Two ports reach any word in the same cycle; in a same-address double write port b's byte lanes win.
// - Control, address and data are registered on the clock and read data leaves a register.
// - Each port has a burst counter loaded from outside that then advances by itself.
// - The write strobe is internal and is high in every sampled cycle with select and write asserted and mask load deasserted.
// - A deasserted chip enable for one sampled cycle powers the port down.
// - One cycle with both enables asserted is needed before outputs come back.
// - Address width is 17, 18 or 19 bits by depth, data is always 18 bits.
// - An asynchronous global reset clears the port registers but not the array or its read registers.
// - Byte enables write the upper and lower lanes separately.
// - A mask limits the counted bits and a flag rises when the counter wraps.
module sdp_ram
    import sdp_pkg::*;
#(
    parameter int AW = ADDR_W_128K
)(
    input  wire logic              mclk_in,
    input  wire logic              reset_n_in,
    input  wire logic              global_async_reset_in,
    input  wire sdp_ctrl_type      a_ctrl_in,
    input  wire logic [AW-1:0]     a_addr_in,
    input  wire logic [DATA_W-1:0] a_wdata_in,
    output logic [DATA_W-1:0]      a_rdata_out,
    output logic                   a_rvalid_out,
    output logic                   a_wrap_flag_out,
    input  wire sdp_ctrl_type      b_ctrl_in,
    input  wire logic [AW-1:0]     b_addr_in,
    input  wire logic [DATA_W-1:0] b_wdata_in,
    output logic [DATA_W-1:0]      b_rdata_out,
    output logic                   b_rvalid_out,
    output logic                   b_wrap_flag_out
);
    // =========================================================
    // Checks
    // =========================================================
    // legal depths only
    if (AW != ADDR_W_128K && AW != ADDR_W_256K && AW != ADDR_W_512K)
    begin : g_bad_aw
        $error("sdp_ram: unsupported address width");
    end

    wire rst_n = reset_n_in && global_async_reset_in;

    logic [DATA_W-1:0]     mem [2**AW];
    logic [AW-1:0]         addr_a, addr_b;
    logic                  we_a, we_b;
    logic [BYTE_LANES-1:0] be_a, be_b;
    logic [DATA_W-1:0]     wd_a, wd_b, rd_a, rd_b;

    sdp_port #(.AW(AW)) u_a (
        .mclk_in(mclk_in), .reset_n_in(rst_n), .ctrl_in(a_ctrl_in),
        .addr_in(a_addr_in), .wdata_in(a_wdata_in), .mem_rdata_in(rd_a),
        .mem_addr_out(addr_a), .mem_we_out(we_a), .mem_be_out(be_a),
        .mem_wdata_out(wd_a), .rdata_out(a_rdata_out), .rvalid_out(a_rvalid_out),
        .wrap_flag_out(a_wrap_flag_out)
    );
    sdp_port #(.AW(AW)) u_b (
        .mclk_in(mclk_in), .reset_n_in(rst_n), .ctrl_in(b_ctrl_in),
        .addr_in(b_addr_in), .wdata_in(b_wdata_in), .mem_rdata_in(rd_b),
        .mem_addr_out(addr_b), .mem_we_out(we_b), .mem_be_out(be_b),
        .mem_wdata_out(wd_b), .rdata_out(b_rdata_out), .rvalid_out(b_rvalid_out),
        .wrap_flag_out(b_wrap_flag_out)
    );

    // =========================================================
    // Shared array
    // =========================================================
    // both ports every cycle; on a same-lane collision port b's write wins
    always_ff @(posedge mclk_in)
    begin
        rd_a <= mem[addr_a];
        rd_b <= mem[addr_b];
        for (int l = 0; l < BYTE_LANES; l++)
        begin
            if (we_a && be_a[l])
                mem[addr_a][l*BYTE_W +: BYTE_W] <= wd_a[l*BYTE_W +: BYTE_W];
            if (we_b && be_b[l])
                mem[addr_b][l*BYTE_W +: BYTE_W] <= wd_b[l*BYTE_W +: BYTE_W];
        end
    end
endmodule : sdp_ram

// ### test/sdp_hosts.sv
`timescale 1ns/1ns
// ====================
// Hosts of both ports
// ====================
module sdp_hosts
    import sdp_pkg::*;
#(
    parameter int AW = ADDR_W_128K
)(
    input  wire sdp_ctrl_type  a_req_in,
    input  wire sdp_ctrl_type  b_req_in,
    input  wire logic [AW-1:0] a_addr_in,
    input  wire logic [AW-1:0] b_addr_in,
    output sdp_ctrl_type       a_ctrl_out,
    output sdp_ctrl_type       b_ctrl_out
);
    wire clash = !a_req_in.write_n && !b_req_in.write_n && a_addr_in == b_addr_in;
    assign a_ctrl_out = a_req_in;
    assign b_ctrl_out = clash ? {b_req_in[7:2], 2'b11} : b_req_in;
endmodule : sdp_hosts

// ### test/sdp_ram_checker.sv
`timescale 1ns/1ns
// ====================
// Port checks
// ====================
module sdp_ram_checker
    import sdp_pkg::*;
(
    input wire logic              mclk_in,
    input wire logic              reset_n_in,
    input wire logic              global_async_reset_in,
    input wire sdp_ctrl_type      a_ctrl_in,
    input wire sdp_ctrl_type      b_ctrl_in,
    input wire logic [DATA_W-1:0] a_rdata_out,
    input wire logic [DATA_W-1:0] b_rdata_out,
    input wire logic              a_rvalid_out,
    input wire logic              b_rvalid_out,
    input wire logic              a_wrap_flag_out
);
    wire ok = reset_n_in && global_async_reset_in;
    wire sa = !a_ctrl_in.chip_sel_low_active && a_ctrl_in.chip_sel_high_active;
    wire sb = !b_ctrl_in.chip_sel_low_active && b_ctrl_in.chip_sel_high_active;
    wire ra = sa && a_ctrl_in.mask_load_n && a_ctrl_in.write_n;
    wire rb = sb && b_ctrl_in.mask_load_n && b_ctrl_in.write_n;
    wire ka = a_ctrl_in.addr_strobe_n;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!ok);
    a_read_lat_a: assert property (ra && $past(sa) |-> ##[3:4] a_rvalid_out)
        else $error("port a read gave no data");
    b_read_lat_a: assert property (rb && $past(sb) |-> ##[3:4] b_rvalid_out)
        else $error("port b read gave no data");
    a_valid_cause_a: assert property (a_rvalid_out |-> $past(ra, 3) || $past(ra, 4))
        else $error("port a data without read");
    b_valid_cause_a: assert property (b_rvalid_out |-> $past(rb, 3) || $past(rb, 4))
        else $error("port b data without read");
    a_data_hold_a: assert property (!a_rvalid_out |-> $stable(a_rdata_out))
        else $error("port a data moved");
    b_data_hold_a: assert property (!b_rvalid_out |-> b_rdata_out == $past(b_rdata_out))
        else $error("port b data moved");
    wrap_held_a: assert property (a_wrap_flag_out && ka && $past(ka) && $past(ka, 2) |=> a_wrap_flag_out)
        else $error("wrap flag dropped");
    wrap_clear_a: assert property ($fell(a_wrap_flag_out) |-> !$past(ka) || !$past(ka, 2) || !$past(ka, 3))
        else $error("wrap flag cleared without load");
    reset_clear_a: assert property (disable iff (1'b0) !ok |-> !a_rvalid_out && a_rdata_out == RDATA_RESET && a_wrap_flag_out == WRAP_RESET)
        else $error("outputs not cleared in reset");
endmodule : sdp_ram_checker
bind sdp_ram sdp_ram_checker chk (.*);

// ### test/test_sync_dual_port_ram_port.sv
`timescale 1ns/1ns
// ====================
// Dual-port bench
// ====================
module test_sync_dual_port_ram_port
    import sdp_pkg::*;
();
    localparam int           AW  = ADDR_W_128K;
    localparam sdp_ctrl_type OFF = 8'hBF;
    logic                    mclk_in = 1'b0;
    logic                    reset_n_in = 1'b1;
    logic                    gr_n = 1'b1;
    sdp_ctrl_type            rq [2], dq [2], hc [2];
    logic [AW-1:0]           ad [2], ex [2], da [2];
    logic [DATA_W-1:0]       wd [2], dw [2], rd [2], mem [16], q [2][$];
    logic                    rv [2], wf [2];
    bit                      was [2];
    int                      fails = 0, n_tests = 0, i;
    logic [31:0]             x;
    sdp_hosts #(.AW(AW)) host (.a_req_in(dq[0]), .b_req_in(dq[1]), .a_addr_in(da[0]),
        .b_addr_in(da[1]), .a_ctrl_out(hc[0]), .b_ctrl_out(hc[1]));
    sdp_ram #(.AW(AW)) dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .global_async_reset_in(gr_n), .a_ctrl_in(hc[0]), .a_addr_in(da[0]),
        .a_wdata_in(dw[0]), .a_rdata_out(rd[0]), .a_rvalid_out(rv[0]),
        .a_wrap_flag_out(wf[0]), .b_ctrl_in(hc[1]), .b_addr_in(da[1]), .b_wdata_in(dw[1]),
        .b_rdata_out(rd[1]), .b_rvalid_out(rv[1]), .b_wrap_flag_out(wf[1]));
    function automatic sdp_ctrl_type mk(logic lo, hi, ks, cn, ml, wn, logic [1:0] be);
        return {lo, hi, ks, cn, ml, wn, be};
    endfunction : mk
    function automatic logic [17:0] merge(logic [17:0] o, n, logic [1:0] be_n);
        return {be_n[1] ? o[17:9] : n[17:9], be_n[0] ? o[8:0] : n[8:0]};
    endfunction : merge
    task automatic cmp(logic [17:0] v, e);
        n_tests++;
        if (v !== e)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, v, e);
        end
    endtask : cmp
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic go();
        logic s, cl;
        cl = !rq[0].write_n && !rq[1].write_n && ad[0] == ad[1];
        @(posedge mclk_in);
        for (int p = 0; p < 2; p++)
        begin
            s = !rq[p].chip_sel_low_active && rq[p].chip_sel_high_active && rq[p].mask_load_n;
            if (s && !rq[p].write_n)
                mem[ad[p][3:0]] = merge(mem[ad[p][3:0]], wd[p], rq[p].byte_en_n | {2{p == 1 && cl}});
            else if (s && was[p])
                q[p].push_back(mem[rq[p].addr_strobe_n ? ex[p][3:0] : ad[p][3:0]]);
            was[p] = !rq[p].chip_sel_low_active && rq[p].chip_sel_high_active;
            dq[p] <= rq[p];
            da[p] <= ad[p];
            dw[p] <= wd[p];
        end
    endtask : go
    task automatic idle(int n);
        rq = '{OFF, OFF};
        repeat (n) go();
    endtask : idle
    initial forever #5 mclk_in = ~mclk_in;
    initial
    begin
        #20000;
        fails++;
        results();
    end
    always @(negedge mclk_in)
        for (int p = 0; p < 2; p++)
            if (rv[p] === 1'b1)
                cmp(rd[p], q[p].size() ? q[p].pop_front() : ~rd[p]);
    initial
    begin
        // A real falling edge, so every reset branch runs before the first clock
        reset_n_in <= 1'b0;
        x = $urandom(32'h6a398d0f);
        rq = '{OFF, OFF};
        dq = '{OFF, OFF};
        ad = '{17'h00000, 17'h00000};
        ex = ad;
        da = ad;
        wd = '{18'h00000, 18'h00000};
        dw = wd;
        repeat (4) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        cmp(rd[0], RDATA_RESET);
        // Both ports write the 16 words first (hosts mask port b); then port a writes the upper half, reads the lower half, so no read meets a fresh write
        for (i = 0; i < 76; i++)
        begin
            x = $urandom;
            for (int p = 0; p < 2; p++)
            begin
                rq[p] = mk(0, i < 16 || p == 0, 0, 1, 1, i >= 16 && x[8+p],
                           i < 16 ? 2'b00 : x[11+2*p+:2]);
                ad[p] = i < 16 ? 17'(i) : 17'({!x[8+p], x[2:0] ^ (p ? x[6:4] : 3'h0)});
                wd[p] = 18'($urandom);
            end
            go();
        end
        // Same word on both ports, a deselect on each enable in mid-stream
        for (i = 0; i < 16; i++)
        begin
            rq = '{mk(i == 5, 1, 0, 1, 1, 1, 2'b00), mk(0, i != 5, 0, 1, 1, 1, 2'b00)};
            ad = '{17'(i), 17'(i)};
            go();
        end
        rq = '{mk(0, 1, 1, 1, 0, 1, 2'b00), OFF};
        ad[0] = 17'h00003;
        go();
        rq[0] = mk(0, 1, 0, 1, 1, 1, 2'b00);
        ad[0] = 17'h0000A;
        go();
        for (i = 0; i < 3; i++)
        begin
            rq[0] = mk(0, 1, 1, 0, 1, 1, 2'b00);
            ex[0] = 17'h00008 | 17'((i + 3) & 3);
            go();
        end
        idle(6);
        cmp(wf[0], 1'b1);
        cmp(wf[1], WRAP_RESET);
        rq[0] = mk(0, 1, 0, 1, 1, 1, 2'b00);
        go();
        idle(6);
        cmp(wf[0], WRAP_RESET);
        cmp(18'(q[0].size()), 18'h00000);
        cmp(18'(q[1].size()), 18'h00000);
        gr_n <= 1'b0;
        repeat (2) @(posedge mclk_in);
        cmp(rd[0], RDATA_RESET);
        cmp(rd[1], RDATA_RESET);
        gr_n <= 1'b1;
        idle(2);
        results();
    end
endmodule : test_sync_dual_port_ram_port
